// >>> verification/crcp_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module crcp_cpu_model
    import crcp_pkg::*;
#(
    parameter int LAT = 3
) (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic exec_in,
    input wire crcp_wr_t wr_in,
    output logic done_out,
    output logic [15:0] count_out,
    output logic [7:0][15:0] regs_out
);
    logic [3:0] busy;
    // an instruction takes LAT cycles; a new one starts only when idle
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            busy <= 4'h0;
            done_out <= 1'b0;
            count_out <= 16'h0;
            regs_out <= '0;
        end else begin
            done_out <= busy == 4'h1;
            if (busy == 4'h1)
                count_out <= count_out + 16'h1;
            if (busy != 4'h0)
                busy <= busy - 4'h1;
            else if (exec_in)
                busy <= LAT[3:0];
            if (wr_in.valid)
                regs_out[wr_in.target] <= wr_in.data;
        end
    end
endmodule
`default_nettype wire

// >>> verification/crcp_panel_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "crcp_regs.svh"
module crcp_chk
    import crcp_pkg::*;
#(
    parameter int WORD_W = 16
) (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire crcp_keys_t keys_in,
    input wire logic [2:0] source_sel_in,
    input wire logic [1:0] run_rate_in,
    input wire logic [1:0] key_lock_in,
    input wire logic [3:0] operator_sense_switches_in,
    input wire logic [WORD_W-1:0] skip_code_in,
    input wire logic overflow_in,
    input wire logic int_armed_in,
    input wire logic cpu_reset_out,
    input wire logic boot_start_out,
    input wire logic exec_enable_out,
    input wire logic halted_out,
    input wire logic skip_out,
    input wire logic display_blank_out,
    input wire crcp_wr_t write_out,
    input wire logic overflow_lamp_out,
    input wire logic armed_lamp_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    ////////////////////////////////////////////////////////////////////////
    // only the four sense codes of each family are judged here
    logic [3:0] sk_sel;
    logic sk_rel;
    logic sk_exp;
    logic free_ok;
    assign sk_sel = skip_code_in[3:0];
    assign sk_rel = (sk_sel inside {4'h1, 4'h2, 4'h4, 4'h8}) &&
        (skip_code_in[15:4] == 12'h080 || skip_code_in[15:4] == 12'h0a0);
    // bit 9 set marks the skip-if-clear family, so it flips the test
    assign sk_exp = (|(operator_sense_switches_in & sk_sel)) ^ skip_code_in[9];
    // keys that the lock would swallow, or that init would override
    assign free_ok = key_lock_in != `CRCP_KEY_LOCK && !keys_in.init;
    ////////////////////////////////////////////////////////////////////////
    chk_skip_sense: assert property (
        sk_rel |=> skip_out == $past(sk_exp)) else $error("skip mismatch");
    chk_ovf_lamp: assert property (
        $past(nrst_in) |-> overflow_lamp_out == $past(overflow_in))
        else $error("overflow lamp wrong");
    chk_armed_lamp: assert property (
        $past(nrst_in) |-> armed_lamp_out == $past(int_armed_in))
        else $error("armed lamp wrong");
    chk_init_halts: assert property (
        keys_in.init && key_lock_in == `CRCP_KEY_NORMAL
        |=> cpu_reset_out && halted_out) else $error("init not halted");
    chk_boot_go: assert property (
        keys_in.init && key_lock_in == `CRCP_KEY_BOOT
        |=> boot_start_out && !halted_out) else $error("boot not started");
    chk_lock_ignore: assert property (
        key_lock_in == `CRCP_KEY_LOCK && halted_out
        |=> halted_out && !cpu_reset_out && !write_out.valid)
        else $error("locked key acted");
    chk_enter_write: assert property (
        keys_in.enter && !keys_in.clear && !keys_in.numeral && free_ok
        |=> write_out.valid && write_out.target == $past(source_sel_in))
        else $error("enter write wrong");
    chk_clear_blank: assert property (
        keys_in.clear && !keys_in.init |=> display_blank_out)
        else $error("display not blanked");
    chk_step_one: assert property (
        halted_out && keys_in.run && !keys_in.halt && free_ok &&
        run_rate_in == `CRCP_RATE_STEP |=> exec_enable_out ##1 !exec_enable_out)
        else $error("step not single");
    chk_halt_stops: assert property (
        keys_in.halt && !keys_in.run && free_ok |=> !exec_enable_out)
        else $error("halt left enable");
    chk_halt_idle: assert property (
        halted_out && $past(halted_out) |-> !exec_enable_out)
        else $error("enabled while halted");
    cover property (keys_in.init && key_lock_in == `CRCP_KEY_BOOT);
    cover property (write_out.valid && write_out.target == 3'h7);
    cover property (sk_rel && skip_out);
endmodule
bind crcp_panel crcp_chk #(.WORD_W(WORD_W)) u_chk (.*);
`default_nettype wire

// >>> verification/test_crcp_panel.sv
`timescale 1ns/1ps
`default_nettype none
module test_crcp_panel
    import crcp_pkg::*;
;
    localparam logic [8:0] k_init = 9'h001;
    localparam logic [8:0] k_run = 9'h002;
    localparam logic [8:0] k_halt = 9'h004;
    localparam logic [8:0] k_enter = 9'h008;
    localparam logic [8:0] k_clear = 9'h100;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    crcp_keys_t keys;
    logic [2:0] sel;
    logic [1:0] rate, lock;
    logic [15:0] rset, code, disp, cnt, ev, c0, wr_addr;
    logic [3:0] sw;
    logic ovf, arm, rst_o, boot, exen, halted, skip, blank, ovl, arl, done;
    crcp_wr_t wr;
    logic [7:0][15:0] regs;
    logic [15:0] exp_v [8];
    int fail_count = 0;
    int cmp_count = 0;
    int n_wr = 0;
    int n_rst = 0;
    int n_boot = 0;
    int w0, r0;
    always #2.5 clk = ~clk;
    crcp_panel dut (.clock_in(clk), .nrst_in(nrst), .keys_in(keys),
        .source_sel_in(sel), .run_rate_in(rate), .rate_setting_in(rset),
        .key_lock_in(lock), .operator_sense_switches_in(sw),
        .acc_in(regs[0]), .sec_acc_in(regs[1]), .index_in(regs[2]),
        .pc_in(regs[3]), .mem_at_pc_in(regs[4]), .mem_at_pc1_in(regs[5]),
        .mem_at_addr_in(regs[7]), .instr_done_in(done), .skip_code_in(code),
        .overflow_in(ovf), .int_armed_in(arm), .cpu_reset_out(rst_o),
        .boot_start_out(boot), .exec_enable_out(exen), .halted_out(halted),
        .skip_out(skip), .display_out(disp), .display_blank_out(blank),
        .write_out(wr), .overflow_lamp_out(ovl), .armed_lamp_out(arl));
    crcp_cpu_model #(.LAT(3)) cpu (.clock_in(clk), .nrst_in(nrst),
        .exec_in(exen), .wr_in(wr), .done_out(done), .count_out(cnt),
        .regs_out(regs));
    // pulse outputs are counted here so tests need not catch the cycle
    always @(posedge clk) begin
        n_wr += int'(wr.valid);
        n_rst += int'(rst_o);
        n_boot += int'(boot);
        if (wr.valid)
            wr_addr = wr.addr;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("compares=%0d mismatches=%0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chb(input logic g, input logic e);
        chk({15'h0, g}, {15'h0, e});
    endtask
    task automatic key(input logic [8:0] k);
        @(posedge clk) keys <= k;
        @(posedge clk) keys <= '0;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // halt may wait for the instruction in flight, so bound the wait
    task automatic wait_halt();
        int i;
        for (i = 0; i < 300; i++) begin
            #1;
            if (halted === 1'b1)
                break;
            @(posedge clk);
        end
        if (i == 300) begin
            fail_count++;
            report_and_stop();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #400000;
        fail_count++;
        report_and_stop();
    end
    initial begin
        keys = '0; sel = 3'h0; rate = 2'h0; lock = 2'h0; rset = 16'h0;
        code = 16'h0400; sw = 4'h0; ovf = 1'b0; arm = 1'b0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        tick(1);
        chb(halted, 1'b1);
        // compose a value per source in halt, six digits so two bits overflow
        for (int t = 0; t < 8; t++) begin
            @(posedge clk) sel <= t[2:0];
            key(k_clear);
            tick(0);
            chb(blank, 1'b1);
            ev = 16'h0;
            for (int j = 0; j < 6; j++) begin
                key({2'b01, 3'(t + 3 * j), 4'h0});
                ev = {ev[12:0], 3'(t + 3 * j)};
            end
            exp_v[t] = ev;
            key(k_enter);
            tick(2);
            chk(regs[t], ev);
            chb(blank, 1'b0);
        end
        // the memory data write carries the address keyed in just before
        chk(wr_addr, exp_v[6]);
        // leave entry mode, then every source must show its own word
        for (int s = 7; s >= 0; s--) begin
            @(posedge clk) sel <= s[2:0];
            tick(2);
            chk(disp, exp_v[s]);
        end
        // lock swallows run, init, enter and halt
        w0 = n_wr; r0 = n_rst;
        @(posedge clk) lock <= `CRCP_KEY_LOCK;
        key(k_run); key(k_init); key(k_enter); key(k_halt);
        tick(3);
        chb(halted, 1'b1);
        chk(16'(n_wr - w0 + n_rst - r0), 16'h0);
        @(posedge clk) lock <= `CRCP_KEY_NORMAL;
        key(k_init);
        tick(2);
        chk(16'(n_rst - r0), 16'h1);
        chb(halted, 1'b1);
        // bootstrap position: init starts the loader and runs
        @(posedge clk) lock <= `CRCP_KEY_BOOT;
        key(k_init);
        tick(2);
        chb(halted, 1'b0);
        chk(16'(n_boot), 16'h1);
        key(k_halt);
        wait_halt();
        @(posedge clk) lock <= `CRCP_KEY_NORMAL;
        // two back-to-back single steps, one instruction each
        @(posedge clk) rate <= `CRCP_RATE_STEP;
        for (int p = 0; p < 2; p++) begin
            c0 = cnt;
            key(k_run);
            wait_halt();
            tick(8);
            chk(cnt, c0 + 16'h1);
        end
        // full speed: back-to-back instructions until halt
        @(posedge clk) rate <= `CRCP_RATE_FULL;
        c0 = cnt;
        key(k_run);
        tick(40);
        key(k_halt);
        wait_halt();
        chb(cnt - c0 >= 16'h8, 1'b1);
        chk({12'h0, cpu.busy}, 16'h0);
        c0 = cnt;
        tick(20);
        chk(cnt, c0);
        // variable rate: one tick each ten cycles
        @(posedge clk) rate <= `CRCP_RATE_VAR;
        rset <= 16'h9;
        c0 = cnt;
        key(k_run);
        tick(100);
        key(k_halt);
        wait_halt();
        chb(cnt - c0 >= 16'h8 && cnt - c0 <= 16'hc, 1'b1);
        // each sense code of both families on two switch patterns
        for (int p = 0; p < 2; p++) begin
            @(posedge clk) sw <= p ? 4'ha : 4'h5;
            for (int i = 0; i < 8; i++) begin
                @(posedge clk) code <= (i < 4 ? 16'h0800 : 16'h0a00) |
                    (16'h1 << (i % 4));
                tick(1);
                chb(skip, sw[i % 4] ^ (i >= 4));
            end
        end
        @(posedge clk) ovf <= 1'b1;
        tick(2);
        chb(ovl, 1'b1);
        chb(arl, 1'b0);
        @(posedge clk) ovf <= 1'b0;
        arm <= 1'b1;
        tick(2);
        chb(ovl, 1'b0);
        chb(arl, 1'b1);
        report_and_stop();
    end
endmodule
`default_nettype wire

// >>> verilog/crcp_panel.sv
// Function
// - master clear resets control logic and, in normal key position, leaves processor halted
// - halt stops only after the current instruction completes
// - run starts processor at the rate the selector gives
// - full speed position runs instructions continuously at maximum rate
// - single step position executes exactly one instruction per run
// - variable position runs continuously at operator-set reduced rate
// - source selector picks register or memory word for the display
// - clear key blanks display and hands it to operator entry
// - each numeral key shifts its digit into the display value
// - enter writes the keyed-in entry value to the selected register or memory
// - four sense switches readable by skip-if-set and skip-if-clear codes
// - normal key position leaves every control working
// - lock position ignores enter, halt, master clear and run
// - bootstrap position plus master clear starts the bootstrap loader
// - overflow lamp follows the processor overflow flag
// - interrupt-armed lamp follows the processor arm state
`include "crcp_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module crcp_panel
    import crcp_pkg::*;
#(
    parameter int WORD_W = `CRCP_WORD_W,
    parameter int RATE_W = `CRCP_RATE_CNT_W
) (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire crcp_keys_t keys_in,
    input wire logic [2:0] source_sel_in,
    input wire logic [1:0] run_rate_in,
    input wire logic [RATE_W-1:0] rate_setting_in,
    input wire logic [1:0] key_lock_in,
    input wire logic [3:0] operator_sense_switches_in,
    input wire logic [WORD_W-1:0] acc_in,
    input wire logic [WORD_W-1:0] sec_acc_in,
    input wire logic [WORD_W-1:0] index_in,
    input wire logic [WORD_W-1:0] pc_in,
    input wire logic [WORD_W-1:0] mem_at_pc_in,
    input wire logic [WORD_W-1:0] mem_at_pc1_in,
    input wire logic [WORD_W-1:0] mem_at_addr_in,
    input wire logic instr_done_in,
    input wire logic [WORD_W-1:0] skip_code_in,
    input wire logic overflow_in,
    input wire logic int_armed_in,
    output logic cpu_reset_out,
    output logic boot_start_out,
    output logic exec_enable_out,
    output logic halted_out,
    output logic skip_out,
    output logic [WORD_W-1:0] display_out,
    output logic display_blank_out,
    output crcp_wr_t write_out,
    output logic overflow_lamp_out,
    output logic armed_lamp_out
);
    ////////////////////////////////////////////////////////////////////
    // key lock gating and decode helpers
    ////////////////////////////////////////////////////////////////////
    logic locked;
    logic do_run;
    logic do_halt;
    logic do_init;
    logic do_enter;
    logic rate_tick;

    // one-hot sense switch select from a skip code, or 4'h0 when not a switch test
    function automatic logic [3:0] switch_pick(input logic [WORD_W-1:0] c,
                                               input logic [WORD_W-1:0] base);
        logic [3:0] sel;
        sel = 4'h0;
        if ((c & `CRCP_SKIP_SEL_MASK) == base) begin
            unique case (c[3:0])
                4'h1: sel = 4'h1;
                4'h2: sel = 4'h2;
                4'h4: sel = 4'h4;
                4'h8: sel = 4'h8;
                default: sel = 4'h0;
            endcase
        end
        return sel;
    endfunction

    // lock position swallows the four operating switches
    // lock suppresses switches
    assign locked = (key_lock_in == `CRCP_KEY_LOCK);
    assign do_run = keys_in.run && !locked;
    assign do_halt = keys_in.halt && !locked;
    assign do_init = keys_in.init && !locked;
    assign do_enter = keys_in.enter && !locked;

    ////////////////////////////////////////////////////////////////////
    // run control
    ////////////////////////////////////////////////////////////////////
    crcp_state_t state;
    crcp_state_t next_state;
    logic exec_en;
    logic next_exec_en;
    logic cpu_rst;
    logic next_cpu_rst;
    logic boot;
    logic next_boot;
    logic var_mode;
    logic next_var_mode;
    logic active;
    logic next_active;
    logic halted;
    logic next_halted;

    // the divider only counts while running at the variable rate
    crcp_rate_div #(
        .CNT_W(RATE_W)
    ) u_rate (
        .clock_in(clock_in),
        .nrst_in(nrst_in),
        .enable_in(state == CRCP_RUN && var_mode),
        .setting_in(rate_setting_in),
        .tick_out(rate_tick)
    );

    // exec_enable is a permit to start an instruction; the processor
    // finishes whatever it began even after the permit drops
    always_comb begin
        next_state = state;
        next_cpu_rst = 1'b0;
        next_boot = 1'b0;
        next_var_mode = var_mode;
        next_exec_en = 1'b0;
        // an instruction is in flight from its permit until its done pulse
        next_active = exec_en || (active && !instr_done_in);
        if (do_init) begin
            next_cpu_rst = 1'b1;
            next_active = 1'b0;
            next_state = CRCP_HALT;
            next_var_mode = 1'b0;
            if (key_lock_in == `CRCP_KEY_BOOT) begin
                next_boot = 1'b1;
                next_state = CRCP_RUN;
            end
        end else begin
            unique case (state)
                CRCP_HALT: begin
                    if (do_run) begin
                        unique case (run_rate_in)
                            `CRCP_RATE_STEP: begin
                                next_state = CRCP_STEP;
                                next_exec_en = 1'b1;
                            end
                            `CRCP_RATE_VAR: begin
                                next_state = CRCP_RUN;
                                next_var_mode = 1'b1;
                            end
                            default: begin
                                next_state = CRCP_RUN;
                                next_var_mode = 1'b0;
                            end
                        endcase
                    end
                end
                CRCP_RUN: begin
                    next_exec_en = var_mode ? rate_tick : 1'b1;
                    if (do_halt) begin
                        next_state = CRCP_STOPPING;
                        next_exec_en = 1'b0;
                    end
                end
                CRCP_STEP: begin
                    // halt is not taken here; a step runs to its end
                    // back to halt
                    if (instr_done_in) begin
                        next_state = CRCP_HALT;
                    end
                end
                CRCP_STOPPING: begin
                    // exec_en is already low here, so only active tells
                    // halt at boundary
                    if (instr_done_in || !active) begin
                        next_state = CRCP_HALT;
                    end
                end
            endcase
        end
        // halted is kept in a flop so the output has no decode glitches
        next_halted = (next_state == CRCP_HALT);
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            state <= CRCP_HALT;
            exec_en <= 1'b0;
            cpu_rst <= 1'b0;
            boot <= 1'b0;
            var_mode <= 1'b0;
            active <= 1'b0;
            halted <= 1'b1;
        end else begin
            state <= next_state;
            exec_en <= next_exec_en;
            cpu_rst <= next_cpu_rst;
            boot <= next_boot;
            var_mode <= next_var_mode;
            active <= next_active;
            halted <= next_halted;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // display and operator entry
    ////////////////////////////////////////////////////////////////////
    logic entry_mode;
    logic next_entry_mode;
    logic [WORD_W-1:0] entry;
    logic [WORD_W-1:0] next_entry;
    logic [WORD_W-1:0] disp;
    logic [WORD_W-1:0] next_disp;
    logic blank;
    logic next_blank;
    logic [WORD_W-1:0] maddr;
    logic [WORD_W-1:0] next_maddr;
    crcp_wr_t wr;
    crcp_wr_t next_wr;

    // the memory address register is panel-held so memory data can use it
    always_comb begin
        next_entry_mode = entry_mode;
        next_entry = entry;
        next_blank = 1'b0;
        next_maddr = maddr;
        next_wr = '0;
        if (keys_in.clear) begin
            next_entry_mode = 1'b1;
            next_entry = '0;
            next_blank = 1'b1;
        end else if (keys_in.numeral) begin
            next_entry_mode = 1'b1;
            next_entry = {entry[WORD_W-`CRCP_DIGIT_W-1:0], keys_in.digit};
        end else if (do_enter) begin
            next_wr.valid = 1'b1;
            next_wr.target = source_sel_in;
            next_wr.addr = maddr;
            next_wr.data = entry;
            // selector 6 also reloads the panel address register
            if (source_sel_in == `CRCP_SRC_MADDR) begin
                next_maddr = entry;
            end
            next_entry_mode = 1'b0;
        end
        // blank holds until the operator types a digit or enters
        if (entry_mode && !keys_in.clear && !keys_in.numeral
            && !do_enter) begin
            next_blank = blank;
        end
        unique case (source_sel_in)
            `CRCP_SRC_ACC: next_disp = acc_in;
            `CRCP_SRC_SEC: next_disp = sec_acc_in;
            `CRCP_SRC_IDX: next_disp = index_in;
            `CRCP_SRC_PC: next_disp = pc_in;
            `CRCP_SRC_INST1: next_disp = mem_at_pc_in;
            `CRCP_SRC_INST2: next_disp = mem_at_pc1_in;
            `CRCP_SRC_MADDR: next_disp = maddr;
            `CRCP_SRC_MDATA: next_disp = mem_at_addr_in;
        endcase
        if (next_entry_mode) begin
            next_disp = next_entry;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            entry_mode <= 1'b0;
            entry <= `CRCP_DISP_RST;
            disp <= `CRCP_DISP_RST;
            blank <= 1'b0;
            maddr <= `CRCP_DISP_RST;
            wr <= '0;
        end else begin
            entry_mode <= next_entry_mode;
            entry <= next_entry;
            disp <= next_disp;
            blank <= next_blank;
            maddr <= next_maddr;
            wr <= next_wr;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sense switch skip and indicators
    ////////////////////////////////////////////////////////////////////
    logic skip;
    logic next_skip;
    logic ovf_lamp;
    logic arm_lamp;

    // the skip answer lags the code by one cycle
    // sense switch skip
    always_comb begin
        next_skip = |(switch_pick(skip_code_in, `CRCP_SKIP_SET_BASE)
                      & operator_sense_switches_in)
                    || |(switch_pick(skip_code_in, `CRCP_SKIP_CLR_BASE)
                         & ~operator_sense_switches_in);
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            skip <= 1'b0;
            ovf_lamp <= 1'b0;
            arm_lamp <= 1'b0;
        end else begin
            skip <= next_skip;
            ovf_lamp <= overflow_in;
            arm_lamp <= int_armed_in;
        end
    end

    assign cpu_reset_out = cpu_rst;
    assign boot_start_out = boot;
    assign exec_enable_out = exec_en;
    assign halted_out = halted;
    assign skip_out = skip;
    assign display_out = disp;
    assign display_blank_out = blank;
    assign write_out = wr;
    assign overflow_lamp_out = ovf_lamp;
    assign armed_lamp_out = arm_lamp;
endmodule
`default_nettype wire

// >>> verilog/crcp_pkg.sv
package crcp_pkg;
    typedef enum logic [1:0] {
        CRCP_HALT,
        CRCP_RUN,
        CRCP_STEP,
        CRCP_STOPPING
    } crcp_state_t;

    // operator key presses, each a one-cycle pulse
    typedef struct packed {
        logic clear;
        logic numeral;
        logic [2:0] digit;
        logic enter;
        logic halt;
        logic run;
        logic init;
    } crcp_keys_t;

    // write-back request to the processor
    typedef struct packed {
        logic valid;
        logic [2:0] target;
        logic [15:0] addr;
        logic [15:0] data;
    } crcp_wr_t;
endpackage

// >>> verilog/crcp_rate_div.sv
`timescale 1ns/1ps
`default_nettype none
// variable-rate step enable: one pulse each time the count reaches the
// operator setting; a setting of zero gives a pulse every cycle
module crcp_rate_div #(
    parameter int CNT_W = 16
) (
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic enable_in,
    input wire logic [CNT_W-1:0] setting_in,
    output logic tick_out
);
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic tick;
    logic next_tick;

    // count up and wrap at the setting
    always_comb begin
        next_count = count;
        next_tick = 1'b0;
        if (!enable_in) begin
            next_count = '0;
        end else if (count >= setting_in) begin
            next_count = '0;
            next_tick = 1'b1;
        end else begin
            next_count = count + 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            count <= '0;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end

    assign tick_out = tick;
endmodule
`default_nettype wire

// >>> verilog/crcp_regs.svh
`ifndef CRCP_REGS_SVH
`define CRCP_REGS_SVH
// processor word width and digit width of the display
`define CRCP_WORD_W 16
`define CRCP_DIGIT_W 3
// sense switch skip instruction codes, octal
`define CRCP_SKIP_SET_BASE 16'o004000
`define CRCP_SKIP_CLR_BASE 16'o005000
`define CRCP_SKIP_SEL_MASK 16'o177760
// display source selector codes
`define CRCP_SRC_ACC 3'h0
`define CRCP_SRC_SEC 3'h1
`define CRCP_SRC_IDX 3'h2
`define CRCP_SRC_PC 3'h3
`define CRCP_SRC_INST1 3'h4
`define CRCP_SRC_INST2 3'h5
`define CRCP_SRC_MADDR 3'h6
`define CRCP_SRC_MDATA 3'h7
// run rate selector codes
`define CRCP_RATE_FULL 2'h0
`define CRCP_RATE_STEP 2'h1
`define CRCP_RATE_VAR 2'h2
// key lock codes
`define CRCP_KEY_NORMAL 2'h0
`define CRCP_KEY_LOCK 2'h1
`define CRCP_KEY_BOOT 2'h2
// reset values and rate counter width
`define CRCP_DISP_RST 16'h0000
`define CRCP_RATE_CNT_W 16
`endif
